/* File: src/preload_timer_consts.vh */
`ifndef PRELOAD_TIMER_CONSTS_VH
`define PRELOAD_TIMER_CONSTS_VH

// register byte addresses
`define OFS_TIMER_CONTROL   8'h00
`define OFS_TIMER_COUNT     8'h04
`define OFS_INT_STATUS      8'h08
`define OFS_INT_MASK        8'h0C
`define OFS_AUX_CONFIG      8'h10

// timer_control field positions
`define CTL_MODE_HI         7
`define CTL_MODE_LO         6
`define CTL_CLK_SEL         5
`define CTL_RUN             4
`define CTL_EDGE            3
`define CTL_PSC_HI          2
`define CTL_PSC_LO          0

// mode field codes
`define MODE_NONE           2'h0
`define MODE_EVENT          2'h1
`define MODE_TIMER          2'h2
`define MODE_CAPTURE        2'h3

// interrupt status bit positions
`define ST_OVERFLOW         0
`define ST_CAPTURE          1
`define ST_WIDTH            2

// aux config bit positions
`define AUX_PWM_EN          0

// reset values
`define CTL_RESET           8'h08
`define COUNT_RESET         8'h00
`define PRELOAD_RESET       8'h00
`define STATUS_RESET        2'h0
`define MASK_RESET          2'h0

// counter full value
`define COUNT_FULL          8'hFF

// prescaler counter width
`define PSC_W               8

// bus responses
`define RESP_OKAY           2'h0
`define RESP_SLVERR         2'h2

`endif

/* File: src/prescale_divider.v */
`timescale 1ns/1ps
`include "preload_timer_consts.vh"

module prescale_divider
(
    // clock and reset
    input  wire       aclk,
    input  wire       aresetn,
    // control
    input  wire       clear,
    input  wire [2:0] ratio_sel,
    // input ticks of the shared timer clock
    input  wire       tick_in,
    // prescaled clock falling-edge tick
    output reg        tick_out
);

    reg  [`PSC_W-1:0] div_q;
    reg  [`PSC_W-1:0] low_mask;
    integer           i;

    // mask of divider bits up to the selected stage
    always @*
    begin
        low_mask = {`PSC_W{1'b0}};
        for (i = 0; i < `PSC_W; i = i + 1)
            if (i <= ratio_sel)
                low_mask[i] = 1'b1;
    end

    // synchronous binary divider, tick when the selected stage falls
    always @(posedge aclk)
    begin
        if (!aresetn || clear)
        begin
            div_q    <= {`PSC_W{1'b0}};
            tick_out <= 1'b0;
        end
        else
        begin
            tick_out <= 1'b0;
            if (tick_in)
            begin
                div_q    <= div_q + {{(`PSC_W-1){1'b0}}, 1'b1};
                tick_out <= ((div_q & low_mask) == low_mask);
            end
        end
    end

endmodule

/* File: src/preload_timer_event_counter.v */
// The register addresses and the AXI4-Lite slave port were decided locally.
`timescale 1ns/1ps
`include "preload_timer_consts.vh"

module preload_timer_event_counter
(
    // clock and reset
    input  wire        aclk,
    input  wire        aresetn,
    // axi4-lite write address
    input  wire [7:0]  awaddr,
    input  wire        awvalid,
    output reg         awready,
    // axi4-lite write data
    input  wire [31:0] wdata,
    input  wire [3:0]  wstrb,
    input  wire        wvalid,
    output reg         wready,
    // axi4-lite write response
    output reg  [1:0]  bresp,
    output reg         bvalid,
    input  wire        bready,
    // axi4-lite read address
    input  wire [7:0]  araddr,
    input  wire        arvalid,
    output reg         arready,
    // axi4-lite read data
    output reg  [31:0] rdata,
    output reg  [1:0]  rresp,
    output reg         rvalid,
    input  wire        rready,
    // pins
    input  wire        external_count_input,
    input  wire        low_speed_crystal,
    // interrupt
    output reg         irq
);

    //--------------------------------------------------------------
    // registers
    //--------------------------------------------------------------

    reg  [7:0]          timer_control_q;
    reg  [7:0]          preload_q;
    reg  [7:0]          count_q;
    reg  [`ST_WIDTH-1:0] status_q;
    reg  [`ST_WIDTH-1:0] mask_q;
    reg                 pwm_en_q;

    reg  [7:0]          aw_addr_q;
    reg                 aw_have_q;
    reg  [7:0]          w_data_q;
    reg                 w_lane0_q;
    reg                 w_have_q;

    reg                 ext_sync1_q;
    reg                 ext_sync2_q;
    reg                 ext_prev_q;
    reg                 lxt_sync1_q;
    reg                 lxt_sync2_q;
    reg                 lxt_prev_q;
    reg                 capture_active_q;

    //--------------------------------------------------------------
    // control fields
    //--------------------------------------------------------------

    wire [1:0] mode_field          = timer_control_q[`CTL_MODE_HI:`CTL_MODE_LO];
    wire       shared_clock_select = timer_control_q[`CTL_CLK_SEL];
    wire       run_control         = timer_control_q[`CTL_RUN];
    wire       edge_select         = timer_control_q[`CTL_EDGE];
    wire [2:0] prescale_sel        = timer_control_q[`CTL_PSC_HI:`CTL_PSC_LO];

    // counting allowed only when running and a mode is chosen
    wire counting_en = run_control && (mode_field != `MODE_NONE);

    //--------------------------------------------------------------
    // pin synchronisers and edge detect
    //--------------------------------------------------------------

    // two stages before any logic looks at the pins
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            ext_sync1_q <= 1'b0;
            ext_sync2_q <= 1'b0;
            ext_prev_q  <= 1'b0;
            lxt_sync1_q <= 1'b0;
            lxt_sync2_q <= 1'b0;
            lxt_prev_q  <= 1'b0;
        end
        else
        begin
            ext_sync1_q <= external_count_input;
            ext_sync2_q <= ext_sync1_q;
            ext_prev_q  <= ext_sync2_q;
            lxt_sync1_q <= low_speed_crystal;
            lxt_sync2_q <= lxt_sync1_q;
            lxt_prev_q  <= lxt_sync2_q;
        end
    end

    wire ext_rise = ext_sync2_q & ~ext_prev_q;
    wire ext_fall = ~ext_sync2_q & ext_prev_q;
    wire lxt_rise = lxt_sync2_q & ~lxt_prev_q;

    //--------------------------------------------------------------
    // shared timer clock and prescaler
    //--------------------------------------------------------------

    // system clock ticks every cycle; crystal ticks per rising edge
    wire use_sys_clock      = pwm_en_q | ~shared_clock_select;
    wire shared_timer_clock = use_sys_clock ? 1'b1 : lxt_rise;

    wire prescaled_tick;

    prescale_divider u_prescale
    (
        .aclk      (aclk),
        .aresetn   (aresetn),
        .clear     (~counting_en),
        .ratio_sel (prescale_sel),
        .tick_in   (shared_timer_clock),
        .tick_out  (prescaled_tick)
    );

    //--------------------------------------------------------------
    // pulse width capture gate
    //--------------------------------------------------------------

    // start/stop edges swap with the edge select bit
    wire cap_start = edge_select ? ext_rise : ext_fall;
    wire cap_stop  = edge_select ? ext_fall : ext_rise;
    wire cap_mode  = counting_en && (mode_field == `MODE_CAPTURE);
    wire cap_done  = cap_mode && capture_active_q && cap_stop;

    // gate opens on start edge, closes on stop edge
    always @(posedge aclk)
    begin
        if (!aresetn)
            capture_active_q <= 1'b0;
        else if (!cap_mode)
            capture_active_q <= 1'b0;
        else if (cap_stop)
            capture_active_q <= 1'b0;
        else if (cap_start)
            capture_active_q <= 1'b1;
    end

    //--------------------------------------------------------------
    // count tick selection
    //--------------------------------------------------------------

    reg count_tick;

    // external edges only in event mode, prescaled shared timer clock in timer and capture modes
    always @*
    begin
        count_tick = 1'b0;
        if (counting_en)
        begin
            case (mode_field)
                `MODE_EVENT:
                    count_tick = edge_select ? ext_fall : ext_rise;
                `MODE_TIMER:
                    count_tick = prescaled_tick;
                `MODE_CAPTURE:
                    count_tick = prescaled_tick & capture_active_q;
                default:
                    count_tick = 1'b0;
            endcase
        end
    end

    wire overflow = count_tick && (count_q == `COUNT_FULL);

    //--------------------------------------------------------------
    // bus write side
    //--------------------------------------------------------------

    wire wr_fire   = aw_have_q & w_have_q & ~bvalid;
    wire wr_ok     = (aw_addr_q == `OFS_TIMER_CONTROL) || (aw_addr_q == `OFS_TIMER_COUNT) ||
                     (aw_addr_q == `OFS_INT_STATUS) || (aw_addr_q == `OFS_INT_MASK) ||
                     (aw_addr_q == `OFS_AUX_CONFIG);
    wire wr_en     = wr_fire & wr_ok & w_lane0_q;
    wire wr_ctl    = wr_en && (aw_addr_q == `OFS_TIMER_CONTROL);
    wire wr_cnt    = wr_en && (aw_addr_q == `OFS_TIMER_COUNT);
    wire wr_stat   = wr_en && (aw_addr_q == `OFS_INT_STATUS);
    wire wr_mask   = wr_en && (aw_addr_q == `OFS_INT_MASK);
    wire wr_aux    = wr_en && (aw_addr_q == `OFS_AUX_CONFIG);

    // address and data taken in either order, held until response
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_addr_q <= 8'h00;
            aw_have_q <= 1'b0;
            w_data_q  <= 8'h00;
            w_lane0_q <= 1'b0;
            w_have_q  <= 1'b0;
            awready   <= 1'b1;
            wready    <= 1'b1;
            bvalid    <= 1'b0;
            bresp     <= `RESP_OKAY;
        end
        else
        begin
            if (awvalid && awready)
            begin
                aw_addr_q <= awaddr;
                aw_have_q <= 1'b1;
                awready   <= 1'b0;
            end
            if (wvalid && wready)
            begin
                w_data_q  <= wdata[7:0];
                w_lane0_q <= wstrb[0];
                w_have_q  <= 1'b1;
                wready    <= 1'b0;
            end
            if (wr_fire)
            begin
                bvalid <= 1'b1;
                bresp  <= wr_ok ? `RESP_OKAY : `RESP_SLVERR;
            end
            if (bvalid && bready)
            begin
                bvalid    <= 1'b0;
                aw_have_q <= 1'b0;
                w_have_q  <= 1'b0;
                awready   <= 1'b1;
                wready    <= 1'b1;
            end
        end
    end

    //--------------------------------------------------------------
    // configuration registers
    //--------------------------------------------------------------

    // control, preload, mask and aux config
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            timer_control_q <= `CTL_RESET;
            preload_q       <= `PRELOAD_RESET;
            mask_q          <= `MASK_RESET;
            pwm_en_q        <= 1'b0;
        end
        else
        begin
            if (wr_ctl)
                timer_control_q <= w_data_q;
            if (wr_cnt)
                preload_q <= w_data_q;
            if (wr_mask)
                mask_q <= w_data_q[`ST_WIDTH-1:0];
            if (wr_aux)
                pwm_en_q <= w_data_q[`AUX_PWM_EN];
        end
    end

    //--------------------------------------------------------------
    // count register
    //--------------------------------------------------------------

    // reload on overflow, else step; stopped counter takes preload writes
    always @(posedge aclk)
    begin
        if (!aresetn)
            count_q <= `COUNT_RESET;
        else if (overflow)
            count_q <= preload_q;
        else if (count_tick)
            count_q <= count_q + 8'h01;
        else if (wr_cnt && !run_control)
            count_q <= w_data_q;
    end

    //--------------------------------------------------------------
    // interrupt status and output
    //--------------------------------------------------------------

    wire [`ST_WIDTH-1:0] st_set = {cap_done, overflow};
    wire [`ST_WIDTH-1:0] st_clr = wr_stat ? w_data_q[`ST_WIDTH-1:0] : {`ST_WIDTH{1'b0}};

    // set wins over a write-one clear in the same cycle
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            status_q <= `STATUS_RESET;
            irq      <= 1'b0;
        end
        else
        begin
            status_q <= (status_q & ~st_clr) | st_set;
            irq      <= |(status_q & mask_q);
        end
    end

    //--------------------------------------------------------------
    // bus read side
    //--------------------------------------------------------------

    reg [31:0] rd_mux;
    reg        rd_ok;

    // read data select
    always @*
    begin
        rd_mux = 32'h0000_0000;
        rd_ok  = 1'b1;
        case (araddr)
            `OFS_TIMER_CONTROL: rd_mux = {24'h000000, timer_control_q};
            `OFS_TIMER_COUNT:   rd_mux = {24'h000000, count_q};
            `OFS_INT_STATUS:    rd_mux = {30'h00000000, status_q};
            `OFS_INT_MASK:      rd_mux = {30'h00000000, mask_q};
            `OFS_AUX_CONFIG:    rd_mux = {31'h00000000, pwm_en_q};
            default:            rd_ok  = 1'b0;
        endcase
    end

    // one read at a time, data registered
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            arready <= 1'b1;
            rvalid  <= 1'b0;
            rdata   <= 32'h0000_0000;
            rresp   <= `RESP_OKAY;
        end
        else
        begin
            if (arvalid && arready)
            begin
                arready <= 1'b0;
                rvalid  <= 1'b1;
                rdata   <= rd_mux;
                rresp   <= rd_ok ? `RESP_OKAY : `RESP_SLVERR;
            end
            else if (rvalid && rready)
            begin
                rvalid  <= 1'b0;
                arready <= 1'b1;
            end
        end
    end

endmodule

/* File: test/timer_bus_checker_asserts.sv */
`timescale 1ns/1ps

// ----------------------------------------
// bus and interrupt checker
// ----------------------------------------
module timer_bus_checker
(
    // clock and reset
    input wire        aclk,
    input wire        aresetn,
    // write channels
    input wire        awvalid,
    input wire        awready,
    input wire        wvalid,
    input wire        wready,
    input wire [1:0]  bresp,
    input wire        bvalid,
    input wire        bready,
    // read channels
    input wire [7:0]  araddr,
    input wire        arvalid,
    input wire        arready,
    input wire [31:0] rdata,
    input wire [1:0]  rresp,
    input wire        rvalid,
    input wire        rready,
    // interrupt
    input wire        irq
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    // read handshake and mapped-address decode
    wire ar_hs  = arvalid && arready;
    wire ar_map = (araddr <= 8'h10) && (araddr[1:0] == 2'h0);

    // write channel
    a_write_answer: assert property (awvalid && awready && wvalid && wready |=> ##1 bvalid)
        else $error("write response missing");
    a_bresp_hold: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
        else $error("write response dropped early");
    a_write_refused: assert property (bvalid |-> !awready && !wready)
        else $error("write accepted while response pending");
    // read channel
    a_read_answer: assert property (ar_hs |=> rvalid)
        else $error("read data missing");
    a_rdata_hold: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
        else $error("read data dropped early");
    a_read_refused: assert property (rvalid |-> !arready)
        else $error("read accepted while data pending");
    a_unmapped_err: assert property (ar_hs && !ar_map |=> rresp == 2'h2 && rdata == 32'h0)
        else $error("unmapped read not refused");
    a_mapped_okay: assert property (ar_hs && ar_map |=> rresp == 2'h0 && rdata[31:8] == 24'h0)
        else $error("mapped read bad response");
    // interrupt quiet after reset
    a_irq_quiet: assert property ($rose(aresetn) |-> !irq && awready && arready)
        else $error("interrupt or ready wrong after reset");

    c_unmapped: cover property (ar_hs && !ar_map);
    c_irq_rise: cover property ($rose(irq));
    c_write_done: cover property (bvalid && bready);
endmodule

bind preload_timer_event_counter timer_bus_checker i_chk
(
    .aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
    .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .irq(irq)
);

/* File: test/testbench.sv */
`timescale 1ns/1ps

module testbench;
    // ----------------------------------------
    // signals
    // ----------------------------------------
    logic        aclk = 1'b0;
    logic        aresetn = 1'b0;
    logic [7:0]  awaddr = 8'h00;
    logic [7:0]  araddr = 8'h00;
    logic        awvalid = 1'b0;
    logic        wvalid = 1'b0;
    logic        bready = 1'b0;
    logic        arvalid = 1'b0;
    logic        rready = 1'b0;
    logic [31:0] wdata = 32'h0;
    logic [3:0]  wstrb = 4'h0;
    logic        ext_in = 1'b0;
    logic        xtal = 1'b0;
    logic [31:0] v;
    wire         awready, wready, bvalid, arready, rvalid, irq;
    wire [1:0]   bresp, rresp;
    wire [31:0]  rdata;
    int          error_cnt = 0;
    int          samples_checked = 0;
    int          cyc = 0;
    int          n;

    preload_timer_event_counter i_dut
    (
        .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
        .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
        .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
        .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
        .external_count_input(ext_in), .low_speed_crystal(xtal), .irq(irq)
    );

    // clock and hang guard
    always #2.5 aclk = ~aclk;
    always @(posedge aclk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            error_cnt++;
            final_report();
        end
    end

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("[ERR] %s expected %0h seen %0h", nm, exp, seen);
        end
    endtask

    // dly holds the ready low for that many edges to exercise the hold rules
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = 2'h0,
                      input int dly = 0);
        int k;
        begin
            k = 0;
            @(posedge aclk);
            awaddr <= a;
            wdata <= d;
            wstrb <= 4'hF;
            awvalid <= 1'b1;
            wvalid <= 1'b1;
            bready <= (dly == 0);
            do
            begin
                @(posedge aclk);
                k++;
                if (awvalid && awready)
                    awvalid <= 1'b0;
                if (wvalid && wready)
                    wvalid <= 1'b0;
                if (k >= dly && !bready)
                    bready <= 1'b1;
            end
            while (!(bvalid && bready) && k < 100);
            bready <= 1'b0;
            chk("bresp", bresp, er);
        end
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] d, input logic [1:0] er = 2'h0,
                      input int dly = 0);
        int k;
        begin
            k = 0;
            @(posedge aclk);
            araddr <= a;
            arvalid <= 1'b1;
            rready <= (dly == 0);
            do
            begin
                @(posedge aclk);
                k++;
                if (arvalid && arready)
                    arvalid <= 1'b0;
                if (k >= dly && !rready)
                    rready <= 1'b1;
            end
            while (!(rvalid && rready) && k < 100);
            rready <= 1'b0;
            d = rdata;
            chk("rresp", rresp, er);
        end
    endtask

    // k whole pulses on the external pin
    task automatic pulse(input int k);
        repeat (k)
        begin
            @(posedge aclk);
            ext_in <= 1'b1;
            repeat (6) @(posedge aclk);
            ext_in <= 1'b0;
            repeat (6) @(posedge aclk);
        end
    endtask

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_regs;
        rd(8'h00, v);
        chk("ctl_reset", v, 32'h08);
        rd(8'h14, v, 2'h2);
        chk("unmapped", v, 32'h0);
        wr(8'h04, 32'h5A);
        rd(8'h04, v, 2'h0, 3);
        chk("stop_copy", v, 32'h5A);
        wr(8'h00, 32'h97);
        wr(8'h00, 32'h87);
        repeat (300) @(posedge aclk);
        rd(8'h04, v);
        chk("run_off", v, 32'h5A);
        $display("regs done");
    endtask

    task automatic t_timer;
        wr(8'h04, 32'hFD);
        wr(8'h0C, 32'h01, 2'h0, 3);
        wr(8'h00, 32'h97);
        wr(8'h04, 32'h20);
        rd(8'h04, v);
        chk("run_hold", v, 32'hFD);
        n = 0;
        while (!irq && n < 2000)
        begin
            @(posedge aclk);
            n++;
        end
        chk("ovf_time", n >= 700 && n <= 800, 1);
        rd(8'h04, v);
        chk("reload", v, 32'h20);
        rd(8'h08, v);
        chk("ovf_flag", v, 32'h01);
        wr(8'h0C, 32'h00);
        repeat (2) @(posedge aclk);
        chk("irq_mask", irq, 1'b0);
        wr(8'h08, 32'h01);
        rd(8'h08, v);
        chk("ovf_clear", v, 32'h00);
        wr(8'h00, 32'h00);
        $display("timer done");
    endtask

    task automatic t_clock;
        wr(8'h04, 32'h00);
        wr(8'h00, 32'hB0);
        repeat (100) @(posedge aclk);
        rd(8'h04, v);
        chk("xtal_idle", v, 32'h00);
        repeat (4)
        begin
            xtal <= 1'b1;
            repeat (4) @(posedge aclk);
            xtal <= 1'b0;
            repeat (4) @(posedge aclk);
        end
        rd(8'h04, v);
        chk("xtal_cnt", v, 32'h02);
        wr(8'h10, 32'h01);
        repeat (40) @(posedge aclk);
        rd(8'h04, v);
        chk("pwm_sys", v >= 20 && v <= 40, 1);
        wr(8'h10, 32'h00);
        wr(8'h00, 32'h00);
        $display("clock done");
    endtask

    task automatic t_event;
        wr(8'h04, 32'h00);
        wr(8'h00, 32'h50);
        pulse(3);
        rd(8'h04, v);
        chk("rise_cnt", v, 32'h03);
        wr(8'h00, 32'h5F);
        pulse(2);
        rd(8'h04, v);
        chk("fall_cnt", v, 32'h05);
        wr(8'h00, 32'h10);
        pulse(2);
        rd(8'h04, v);
        chk("mode_none", v, 32'h05);
        $display("event done");
    endtask

    task automatic t_capture;
        wr(8'h00, 32'h00);
        wr(8'h04, 32'h00);
        wr(8'h00, 32'hD0);
        ext_in <= 1'b1;
        repeat (10) @(posedge aclk);
        ext_in <= 1'b0;
        repeat (40) @(posedge aclk);
        ext_in <= 1'b1;
        repeat (10) @(posedge aclk);
        rd(8'h04, v);
        chk("gate_cnt", v >= 15 && v <= 25, 1);
        n = v;
        repeat (40) @(posedge aclk);
        rd(8'h04, v);
        chk("gate_shut", v, n);
        rd(8'h08, v);
        chk("cap_flag", v, 32'h02);
        // reversed edges: rising opens the gate, falling closes it
        wr(8'h00, 32'hD8);
        ext_in <= 1'b0;
        repeat (10) @(posedge aclk);
        ext_in <= 1'b1;
        repeat (40) @(posedge aclk);
        ext_in <= 1'b0;
        repeat (10) @(posedge aclk);
        rd(8'h04, v);
        chk("gate_rev", v >= n + 15 && v <= n + 25, 1);
        $display("capture done");
    endtask

    task automatic final_report;
        $display("checks %0d mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // main sequence
    initial
    begin
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        t_regs();
        t_timer();
        t_clock();
        t_event();
        t_capture();
        final_report();
    end
endmodule
